// file: rtl/swts_regs.vh
// Constants for the SYSREF windowing, trigger and alarm block.
// Assumes inclusion by the design files under rtl/.
`ifndef SWTS_REGS_VH
`define SWTS_REGS_VH
// ****************************************************************
// Position map
// ****************************************************************
`define SWTS_POS_TAPS      16
`define SWTS_POS_LOW_BIT   0
`define SWTS_POS_HIGH_BIT  15
// ****************************************************************
// Alarm flag bits
// ****************************************************************
`define SWTS_ALM_BITS      7
`define SWTS_ALM_FIFO_EMPTY 0
`define SWTS_ALM_FIFO_FULL  1
`define SWTS_ALM_LVDS_CLK   2
`define SWTS_ALM_LVDS_STR   3
`define SWTS_ALM_TRIG_RE    4
`define SWTS_ALM_CLK_RE     5
`define SWTS_ALM_CLK_ALIGN  6
// ****************************************************************
// Reset values
// ****************************************************************
`define SWTS_RST_ALM       7'h00
`define SWTS_RST_MAP       16'h8001
// ****************************************************************
// Dividers and timing
// ****************************************************************
`define SWTS_SYS_DIV_W     4
`define SWTS_TRIGGER_DIVIDE_RATIO_W    8
`define SWTS_TONE_OFFSET   4
`endif

// file: rtl/swts_tap_sampler.v
// One delay tap of the SYSREF position detector.
// Assumes delayed SYSREF copies arrive synchronous to ref_clk.
`timescale 1ns/1ns
module swts_tap_sampler (
  // Clock and reset
  input  wire ref_clk,
  input  wire reset_n,
  // Tap data
  input  wire tapEarly,
  input  wire tapLate,
  input  wire edgeSeen,
  input  wire accumulate,
  input  wire restart,
  input  wire forceSet,
  output reg  violation_q
);
  wire unstable;
  assign unstable = tapEarly ^ tapLate;
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      // Only the end taps read as flagged straight out of reset
      violation_q <= forceSet;
    end else if (forceSet) begin
      violation_q <= 1'b1;
    end else if (restart) begin
      // An edge in the restart cycle already counts toward the new map
      violation_q <= edgeSeen & unstable;
    end else if (edgeSeen) begin
      // Accumulate keeps every flag seen since restart
      violation_q <= accumulate ? (violation_q | unstable) : unstable;
    end
  end
endmodule // swts_tap_sampler

// file: rtl/swts_sysref_sync.v
// SYSREF windowing, divider realignment, sticky alarms and trigger clock.
// Assumes all inputs synchronous to ref_clk (the converter sample clock).
//
// Contract
// - SYSREF is registered in one chosen sample clock cycle for aligning dividers.
// - Position map holds one bit per tap; 1 marks a timing risk.
// - SYSREF is captured at the tap indexed by the sample select value.
// - Fine step selects finer tap spacing, otherwise coarse spacing.
// - Position map bits 0 and 15 always read as 1.
// - Persistence on accumulates map since enable rose or range last changed; off shows last edge.
// - Alarm flags are sticky until software writes 1 to that bit.
// - Alarm pin asserts only for set, unmasked flags.
// - Mute option holds output muted while any alarm flag is set.
// - Trigger clock is divided sample clock, driven only when both enables set.
// - Every SYSREF rising edge with processing enabled resets the trigger divider.
// - Clock realigned flag sets when SYSREF moves system divider phase.
// - Trigger realigned flag sets when SYSREF moves trigger phase, regardless.
// - Tone selects are sampled on the trigger clock even with output off.
// - Sampled tone selection applies to both channels at fixed SYSREF offset.
// - Up to two SYSREF pulses may be needed to realign the trigger divider.
`timescale 1ns/1ns
`include "swts_regs.vh"
module swts_sysref_sync #(
  parameter TAPS   = `SWTS_POS_TAPS,
  parameter ALMS   = `SWTS_ALM_BITS,
  parameter SDIV_W = `SWTS_SYS_DIV_W,
  parameter TDIV_W = `SWTS_TRIGGER_DIVIDE_RATIO_W
) (
  // Clock and reset
  input  wire              ref_clk,
  input  wire              reset_n,
  // SYSREF taps: bit i is SYSREF through delay tap i, early and late copies
  input  wire [TAPS-1:0]   sysrefTapEarly,
  input  wire [TAPS-1:0]   sysrefTapLate,
  // Windowing control
  input  wire              sysref_receiver_sleep,
  input  wire              sysref_processing_enable,
  input  wire              sysref_realign_enable,
  input  wire [3:0]        sysref_sample_select,
  input  wire              position_step_fine,
  input  wire [1:0]        position_range_select,
  input  wire              position_persistence_enable,
  // Alarm sources and control
  input  wire [ALMS-1:0]   alarmEvents,
  input  wire [ALMS-1:0]   alarmClearWrite,
  input  wire [ALMS-1:0]   alarm_pin_mask,
  input  wire              muteOnAlarmEnable,
  // Trigger and tone control
  input  wire [TDIV_W-1:0] trigger_divide_ratio,
  input  wire              trigger_output_enable,
  input  wire              oscillator_enable,
  input  wire [3:0]        tone_select_inputs,
  input  wire              tone_bank_select_input,
  // Status
  output reg  [TAPS-1:0]   sysref_position_map_q,
  output reg  [ALMS-1:0]   system_alarm_flags_q,
  output reg               alarmPin_q,
  output reg               muteOutput_q,
  output reg               tapStepFine_q,
  output reg               trigger_clock_q,
  output reg  [4:0]        toneSelectChanA_q,
  output reg  [4:0]        toneSelectChanB_q,
  output reg               dividerReset_q
);
  // ****************************************************************
  // SYSREF capture and edge detection
  // ****************************************************************
  reg  sysrefCap_q;
  reg  sysrefPrev_q;
  wire sysrefEdge;
  wire rxActive;
  assign rxActive = ~sysref_receiver_sleep;
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      sysrefCap_q  <= 1'b0;
      sysrefPrev_q <= 1'b0;
    end else begin
      // Selected tap fixes the sample clock cycle that takes SYSREF
      sysrefCap_q  <= rxActive & sysrefTapLate[sysref_sample_select];
      sysrefPrev_q <= sysrefCap_q;
    end
  end
  assign sysrefEdge = sysrefCap_q & ~sysrefPrev_q;
  // ****************************************************************
  // Position detector
  // ****************************************************************
  reg  persistPrev_q;
  reg  [1:0] rangePrev_q;
  wire persistRise;
  wire rangeChanged;
  wire [TAPS-1:0] mapBits;
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      persistPrev_q <= 1'b0;
      rangePrev_q   <= 2'h0;
      tapStepFine_q <= 1'b0;
    end else begin
      persistPrev_q <= position_persistence_enable;
      rangePrev_q   <= position_range_select;
      // Step size goes to the analog delay line; logic just registers it
      tapStepFine_q <= position_step_fine;
    end
  end
  assign persistRise = position_persistence_enable & ~persistPrev_q;
  // A map mixed from two ranges is meaningless, so a range change restarts it too
  assign rangeChanged = |(rangePrev_q ^ position_range_select);
  genvar gi;
  generate
    for (gi = 0; gi < TAPS; gi = gi + 1) begin : gTap
      swts_tap_sampler uTap (
        .ref_clk     (ref_clk),
        .reset_n     (reset_n),
        .tapEarly    (sysrefTapEarly[gi]),
        .tapLate     (sysrefTapLate[gi]),
        .edgeSeen    (sysrefEdge & rxActive),
        .accumulate  (position_persistence_enable),
        .restart     (persistRise | (rangeChanged & position_persistence_enable)),
        .forceSet    ((gi == `SWTS_POS_LOW_BIT) || (gi == `SWTS_POS_HIGH_BIT)),
        .violation_q (mapBits[gi])
      );
    end
  endgenerate
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      sysref_position_map_q <= `SWTS_RST_MAP;
    end else begin
      sysref_position_map_q <= mapBits;
    end
  end
  // ****************************************************************
  // System divider realignment
  // ****************************************************************
  reg  [SDIV_W-1:0] sysDiv_q;
  wire applyReset;
  wire sysPhaseMoved;
  assign applyReset    = sysrefEdge & sysref_processing_enable;
  // Only realign the system divider when realign is enabled
  assign sysPhaseMoved = applyReset & sysref_realign_enable & (sysDiv_q != {SDIV_W{1'b0}});
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      sysDiv_q       <= {SDIV_W{1'b0}};
      dividerReset_q <= 1'b0;
    end else begin
      // Divider and FIFO read pointers restart on the same captured cycle
      dividerReset_q <= applyReset & sysref_realign_enable;
      if (applyReset && sysref_realign_enable) begin
        sysDiv_q <= {{(SDIV_W-1){1'b0}}, 1'b1};
      end else begin
        sysDiv_q <= sysDiv_q + {{(SDIV_W-1){1'b0}}, 1'b1};
      end
    end
  end
  // ****************************************************************
  // Trigger clock divider
  // ****************************************************************
  reg  [TDIV_W-1:0] trigCnt_q;
  reg               trigPhase_q;
  reg               trigPhasePrev_q;
  wire              trigWrap;
  wire              trigPhaseMoved;
  wire              trigRise;
  assign trigWrap = (trigCnt_q >= trigger_divide_ratio);
  // An edge moves the trigger phase unless it lands where the divider would
  // wrap back to phase zero anyway; a repeated pulse there settles it
  assign trigPhaseMoved = applyReset & ~(trigWrap & trigPhase_q);
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      trigCnt_q   <= {TDIV_W{1'b0}};
      trigPhase_q <= 1'b0;
    end else if (applyReset) begin
      trigCnt_q   <= {TDIV_W{1'b0}};
      trigPhase_q <= 1'b0;
    end else if (trigWrap) begin
      trigCnt_q   <= {TDIV_W{1'b0}};
      trigPhase_q <= ~trigPhase_q;
    end else begin
      trigCnt_q <= trigCnt_q + {{(TDIV_W-1){1'b0}}, 1'b1};
    end
  end
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      trigPhasePrev_q <= 1'b0;
      trigger_clock_q <= 1'b0;
    end else begin
      trigPhasePrev_q <= trigPhase_q;
      trigger_clock_q <= trigPhase_q & trigger_output_enable & oscillator_enable;
    end
  end
  assign trigRise = trigPhase_q & ~trigPhasePrev_q;
  // ****************************************************************
  // Tone selection sampling
  // ****************************************************************
  // Sampling ignores the output enable so the pin can be silenced
  reg [4:0] toneSample_q;
  reg [4:0] toneDelay_q [0:`SWTS_TONE_OFFSET-1];
  integer k;
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      toneSample_q <= 5'h00;
      for (k = 0; k < `SWTS_TONE_OFFSET; k = k + 1) begin
        toneDelay_q[k] <= 5'h00;
      end
    end else begin
      if (trigRise) begin
        toneSample_q <= {tone_bank_select_input, tone_select_inputs};
      end
      toneDelay_q[0] <= toneSample_q;
      for (k = 1; k < `SWTS_TONE_OFFSET; k = k + 1) begin
        toneDelay_q[k] <= toneDelay_q[k-1];
      end
    end
  end
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      toneSelectChanA_q <= 5'h00;
      toneSelectChanB_q <= 5'h00;
    end else begin
      // Both channels take the same fixed-latency copy
      toneSelectChanA_q <= toneDelay_q[`SWTS_TONE_OFFSET-1];
      toneSelectChanB_q <= toneDelay_q[`SWTS_TONE_OFFSET-1];
    end
  end
  // ****************************************************************
  // Sticky alarms, pin and mute
  // ****************************************************************
  reg  [ALMS-1:0] almSet;
  always @* begin
    almSet = alarmEvents;
    almSet[`SWTS_ALM_CLK_RE]  = alarmEvents[`SWTS_ALM_CLK_RE] | sysPhaseMoved;
    almSet[`SWTS_ALM_TRIG_RE] = alarmEvents[`SWTS_ALM_TRIG_RE] | trigPhaseMoved;
  end
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      system_alarm_flags_q <= `SWTS_RST_ALM;
    end else begin
      // Set wins over a clear in the same cycle
      system_alarm_flags_q <= (system_alarm_flags_q & ~alarmClearWrite) | almSet;
    end
  end
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      alarmPin_q   <= 1'b0;
      muteOutput_q <= 1'b0;
    end else begin
      alarmPin_q   <= |(system_alarm_flags_q & ~alarm_pin_mask);
      muteOutput_q <= muteOnAlarmEnable & (|system_alarm_flags_q);
    end
  end
endmodule // swts_sysref_sync

// file: test/swts_sync_props.sv
// Port assertions for the SYSREF sync block.
// Assumes a bind onto swts_sysref_sync with default widths.
`timescale 1ns/1ns
module swts_sync_props (
  // Watched ports
  input wire        ref_clk,
  input wire        reset_n,
  input wire [15:0] sysrefTapLate,
  input wire [3:0]  sysref_sample_select,
  input wire [6:0]  alarmEvents,
  input wire [6:0]  alarmClearWrite,
  input wire [6:0]  alarm_pin_mask,
  input wire        trigger_output_enable,
  input wire        oscillator_enable,
  input wire [15:0] sysref_position_map_q,
  input wire [6:0]  system_alarm_flags_q,
  input wire        alarmPin_q,
  input wire        trigger_clock_q,
  input wire [4:0]  toneSelectChanA_q,
  input wire [4:0]  toneSelectChanB_q,
  input wire        dividerReset_q
);
  // ****************
  // Checks
  // ****************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_flag_sticky: assert property (
    ($past(system_alarm_flags_q) & ~$past(alarmClearWrite) & ~system_alarm_flags_q) == 7'h00)
    else $error("alarm flag dropped");
  a_flag_set: assert property (
    ($past(alarmEvents) & ~system_alarm_flags_q) == 7'h00)
    else $error("alarm flag not set");
  a_pin_mask: assert property (
    alarmPin_q == |($past(system_alarm_flags_q) & ~$past(alarm_pin_mask)))
    else $error("alarm pin wrong");
  a_map_ends: assert property (
    sysref_position_map_q[0] && sysref_position_map_q[15])
    else $error("end taps clear");
  a_trig_gate: assert property (
    (!(trigger_output_enable && oscillator_enable)) [*3] |-> !trigger_clock_q)
    else $error("trigger clock driven");
  a_reset_edge: assert property (
    dividerReset_q |-> $past(sysrefTapLate[sysref_sample_select], 2)
      && !$past(sysrefTapLate[sysref_sample_select], 3))
    else $error("divider reset without edge");
  a_reset_pulse: assert property (
    dividerReset_q |=> !dividerReset_q)
    else $error("divider reset too long");
  a_tone_both: assert property (
    toneSelectChanA_q == toneSelectChanB_q)
    else $error("tone channels differ");
endmodule // swts_sync_props
bind swts_sysref_sync swts_sync_props u_props (.ref_clk, .reset_n, .sysrefTapLate,
  .sysref_sample_select, .alarmEvents, .alarmClearWrite, .alarm_pin_mask,
  .trigger_output_enable, .oscillator_enable, .sysref_position_map_q, .system_alarm_flags_q,
  .alarmPin_q, .trigger_clock_q, .toneSelectChanA_q, .toneSelectChanB_q, .dividerReset_q);

// file: test/swts_clkgen_model.sv
// Clock generator model driving SYSREF through the delay taps.
// Assumes requests change after a falling edge of ref_clk.
`timescale 1ns/1ns
module swts_clkgen_model #(
  parameter PERIOD = 16
) (
  // Clock and requests
  input  wire        ref_clk,
  input  wire        pulseReq,
  input  wire        runCont,
  input  wire [15:0] skewMask,
  // SYSREF taps
  output reg  [15:0] tapEarly,
  output reg  [15:0] tapLate
);
  integer cnt = 0;
  integer per = 0;
  // Period is 8 x two buses x 1 so running pulses stay legal
  always @(posedge ref_clk) begin
    per <= (runCont && per < PERIOD - 1) ? per + 1 : 0;
    if (pulseReq || (runCont && per == 0))
      cnt <= 4;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  // Masked taps see early and late copies disagree
  always @* begin
    tapLate  = (cnt > 0) ? 16'hFFFF : 16'h0000;
    tapEarly = tapLate ^ ((cnt > 0) ? skewMask : 16'h0000);
  end
endmodule // swts_clkgen_model

// file: test/swts_sysref_sync_tb.sv
// Self-checking bench for the SYSREF sync block.
// Assumes the clock generator model and the bound checker.
`timescale 1ns/1ns
module swts_sysref_sync_tb;
  reg         ref_clk = 1'b0;
  reg         reset_n = 1'b0;
  reg         sysref_receiver_sleep, sysref_processing_enable, sysref_realign_enable;
  reg  [3:0]  sysref_sample_select, tone_select_inputs;
  reg         position_step_fine, position_persistence_enable, muteOnAlarmEnable;
  reg  [1:0]  position_range_select;
  reg  [6:0]  alarmEvents, alarmClearWrite, alarm_pin_mask;
  reg  [7:0]  trigger_divide_ratio;
  reg         trigger_output_enable, oscillator_enable, tone_bank_select_input;
  reg         pulseReq = 1'b0;
  reg         runCont = 1'b0;
  reg  [15:0] skewMask = 16'h0000;
  wire [15:0] sysrefTapEarly, sysrefTapLate, sysref_position_map_q;
  wire [6:0]  system_alarm_flags_q;
  wire        alarmPin_q, muteOutput_q, tapStepFine_q, trigger_clock_q, dividerReset_q;
  wire [4:0]  toneSelectChanA_q, toneSelectChanB_q;
  integer     badCount = 0;
  integer     checkCount = 0;
  integer     resetSeen = 0;
  integer     i, n;
  swts_clkgen_model gen (.ref_clk, .pulseReq, .runCont, .skewMask,
    .tapEarly(sysrefTapEarly), .tapLate(sysrefTapLate));
  swts_sysref_sync DUT (.ref_clk, .reset_n, .sysrefTapEarly, .sysrefTapLate,
    .sysref_receiver_sleep, .sysref_processing_enable, .sysref_realign_enable,
    .sysref_sample_select, .position_step_fine, .position_range_select,
    .position_persistence_enable, .alarmEvents, .alarmClearWrite, .alarm_pin_mask,
    .muteOnAlarmEnable, .trigger_divide_ratio, .trigger_output_enable, .oscillator_enable,
    .tone_select_inputs, .tone_bank_select_input, .sysref_position_map_q,
    .system_alarm_flags_q, .alarmPin_q, .muteOutput_q, .tapStepFine_q, .trigger_clock_q,
    .toneSelectChanA_q, .toneSelectChanB_q, .dividerReset_q);
  // ****************
  // Tasks
  // ****************
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (dividerReset_q === 1'b1) resetSeen <= resetSeen + 1;
  task tick(input integer k);
    repeat (k) @(negedge ref_clk);
  endtask
  task check(input [8*12:1] what, input [15:0] exp, input [15:0] got);
    begin
      checkCount = checkCount + 1;
      if (got !== exp) begin
        badCount = badCount + 1;
        $display("mismatch %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task send(input [15:0] mask, input integer gap);
    begin
      skewMask = mask;
      pulseReq = 1'b1;
      tick(1);
      pulseReq = 1'b0;
      tick(gap - 1);
    end
  endtask
  task clearFlags(input [6:0] bits);
    begin
      alarmClearWrite = bits;
      tick(1);
      alarmClearWrite = 7'h00;
    end
  endtask
  // Bounded wait for the trigger clock to flip, counting cycles
  task waitFlip;
    reg lvl;
    begin
      lvl = trigger_clock_q;
      n = 0;
      while (trigger_clock_q === lvl && n < 40) begin
        tick(1);
        n = n + 1;
      end
    end
  endtask
  task completeRun;
    begin
      $display("checks %0d mismatches %0d", checkCount, badCount);
      if (badCount == 0 && checkCount > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // ****************
  // Tests
  // ****************
  initial begin
    #200000;
    badCount = badCount + 1;
    completeRun;
  end
  initial begin
    {sysref_processing_enable, sysref_realign_enable, sysref_sample_select, tone_select_inputs,
      position_step_fine, position_persistence_enable, muteOnAlarmEnable, position_range_select,
      alarmEvents, alarmClearWrite, alarm_pin_mask, trigger_divide_ratio, trigger_output_enable,
      oscillator_enable, tone_bank_select_input} = '0;
    sysref_receiver_sleep = 1'b1;
    tick(6);
    reset_n = 1'b1;
    tick(1);
    check("map reset", 16'h8001, sysref_position_map_q);
    sysref_receiver_sleep = 1'b0;
    position_step_fine = 1'b1;
    sysref_processing_enable = 1'b1;
    sysref_realign_enable = 1'b1;
    sysref_sample_select = 4'h7;
    tick(2);
    check("step fine", 16'h0001, {15'h0000, tapStepFine_q});
    send(16'h0030, 8);
    check("map last", 16'h8031, sysref_position_map_q);
    send(16'h0300, 8);
    check("map replace", 16'h8301, sysref_position_map_q);
    position_range_select = 2'h1;
    position_persistence_enable = 1'b1;
    position_step_fine = 1'b0;
    tick(2);
    check("step coarse", 16'h0000, {15'h0000, tapStepFine_q});
    send(16'h0030, 8);
    send(16'h0300, 8);
    check("map accum", 16'h8331, sysref_position_map_q);
    sysref_processing_enable = 1'b0;
    send(16'h0000, 8);
    sysref_processing_enable = 1'b1;
    sysref_receiver_sleep = 1'b1;
    send(16'h0000, 8);
    sysref_receiver_sleep = 1'b0;
    check("resets", 16'h0004, resetSeen[15:0]);
    runCont = 1'b1;
    tick(60);
    sysref_processing_enable = 1'b0;
    tick(4);
    runCont = 1'b0;
    check("resets run", 16'h0008, resetSeen[15:0]);
    sysref_processing_enable = 1'b1;
    trigger_divide_ratio = 8'h03;
    oscillator_enable = 1'b1;
    clearFlags(7'h7F);
    check("cleared", 16'h0000, {9'h000, system_alarm_flags_q});
    send(16'h0000, 14);
    send(16'h0000, 8);
    check("realign", 16'h0030, {9'h000, system_alarm_flags_q & 7'h30});
    sysref_realign_enable = 1'b0;
    clearFlags(7'h7F);
    send(16'h0000, 14);
    send(16'h0000, 8);
    check("trig only", 16'h0010, {9'h000, system_alarm_flags_q & 7'h30});
    trigger_output_enable = 1'b1;
    // Enabling mid half period gives a short first level; time a whole one
    waitFlip;
    waitFlip;
    waitFlip;
    check("trig half", 16'h0004, n[15:0]);
    trigger_output_enable = 1'b0;
    tone_select_inputs = 4'hA;
    tone_bank_select_input = 1'b1;
    tick(30);
    check("tone a", 16'h001A, {11'h000, toneSelectChanA_q});
    check("tone b", 16'h001A, {11'h000, toneSelectChanB_q});
    clearFlags(7'h7F);
    muteOnAlarmEnable = 1'b1;
    for (i = 0; i < 7; i = i + 1) begin
      alarm_pin_mask = ~(7'h01 << i);
      alarmEvents = 7'h01 << i;
      tick(1);
      alarmEvents = 7'h00;
      tick(3);
      check("flag", 16'h0001 << i, {9'h000, system_alarm_flags_q});
      check("pin mute", 16'h0003, {14'h0000, alarmPin_q, muteOutput_q});
      alarm_pin_mask = 7'h7F;
      tick(2);
      check("pin masked", 16'h0000, {15'h0000, alarmPin_q});
      clearFlags(7'h01 << i);
      tick(2);
      check("mute off", 16'h0000, {8'h00, muteOutput_q, system_alarm_flags_q});
    end
    completeRun;
  end
endmodule // swts_sysref_sync_tb
